// ==== logic/arith_register_input_gating.v ====
`timescale 1ns/100ps
`include "arith_gating_defines.vh"

// Summary of operation
// - Clear/set bits 1-8, shift counter jams
// - Bus and switch loads transfer ones only
// - Interior bits take neighbour on shifts
// - Divide select only while flag two clear
// - Left shift: sign takes bit 1 unless arithmetic
// - Right shift sign from quotient 35 or bit 35
// - Right shift sign cleared or held by mode
// - Left shift bit 35 source by mode
// - Bit 35 cleared on single arith/logical shifts, deposit
// - Buffer ones OR, zeros AND, both copy
// - Exclusive OR pulse toggles on buffer ones
// - Complement pulse inverts every bit
// - Carry toggles next more significant bit
// - Increment toggles bit 35, ripples upward
// - Bit 17 takes ripple or own carry pulse
// - Add is partial add then carry initiate
// - Initiate where sum 0 and buffer 1
// - Ripple continues only on one-to-zero toggles
// - Carries extend into the sign bit
// - Carries out of bit 1 and sign exported
module arith_register_input_gating #(
    parameter WORD_W = `ARG_WORD_W,
    parameter CNT_W  = `ARG_CNT_W
) (
    input  wire              clock,
    input  wire              rst_n,
    input  wire              clearPulse,
    input  wire              clearLowBytePulse,
    input  wire              setLowBytePulse,
    input  wire              counterJamPulse,
    input  wire              counterShortJamPulse,
    input  wire [0:CNT_W-1]  shiftCounter,
    input  wire              ioLoadPulse,
    input  wire [0:WORD_W-1] ioBus,
    input  wire              switchLoadPulse,
    input  wire [0:WORD_W-1] dataSwitches,
    input  wire              shiftLeftPulse,
    input  wire              shiftRightPulse,
    input  wire              singleArithShift,
    input  wire              combinedArithShift,
    input  wire              singleLogicalShift,
    input  wire              combinedLogicalShift,
    input  wire              singleRotate,
    input  wire              combinedRotate,
    input  wire              characterLoad,
    input  wire              characterDeposit,
    input  wire              multiplyShift,
    input  wire              divideInstr,
    input  wire              normalizeReturnFlagTwo,
    input  wire [0:WORD_W-1] multiplierQuotient,
    input  wire [0:WORD_W-1] memoryBuffer,
    input  wire              bufferOnesPulse,
    input  wire              bufferZerosPulse,
    input  wire              bufferXorPulse,
    input  wire              complementPulse,
    input  wire              carryInitiatePulse,
    input  wire              increment_pulse,
    input  wire              halfCarryPulse,
    output wire [0:WORD_W-1] arithmeticRegister,
    output wire              divisionShiftSelect,
    output wire              carryOutBitOne,
    output wire              carryOutSign
);

    // ----------------------------------------
    // Ripple chain, one settled pass per cycle
    // ----------------------------------------
    // Returns {carry out of sign, carry out of bit 1, new word}.
    // Both carry sources are ORed: the add algorithm never lets an
    // initiated carry and a ripple land on the same position.
    function [WORD_W+1:0] rippleChain;
        input [0:WORD_W-1] word;
        input [0:WORD_W-1] initInto;
        input              inc;
        input              half;
        reg   [0:WORD_W-1] w;
        reg                c;
        reg                old;
        reg                outOne;
        integer            i;
        begin
            w      = word;
            c      = inc;
            outOne = 1'b0;
            for (i = WORD_W - 1; i >= 0; i = i - 1) begin
                if (i == `ARG_HALF_LSB) begin
                    c = c | half;
                end
                c   = c | initInto[i];
                old = w[i];
                if (c) begin
                    w[i] = ~old;
                end
                if (i == `ARG_SIGN_BIT) begin
                    outOne = c;
                end
                c = c & old;
            end
            rippleChain = {c, outOne, w};
        end
    endfunction

    // ----------------------------------------
    // Console switch synchroniser
    // ----------------------------------------
    // Switches are panel pins; everything else is same-clock logic.
    reg [0:WORD_W-1] switchMeta_q;
    reg [0:WORD_W-1] switchSync_q;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            switchMeta_q <= `ARG_SW_RESET;
            switchSync_q <= `ARG_SW_RESET;
        end else begin
            switchMeta_q <= dataSwitches;
            switchSync_q <= switchMeta_q;
        end
    end

    // ----------------------------------------
    // Composite shift conditions
    // ----------------------------------------
    // Flag two masks floating divide so normalize return is unaffected.
    assign divisionShiftSelect = divideInstr & ~normalizeReturnFlagTwo;

    wire anyArithShift = singleArithShift | combinedArithShift;
    wire holdSignRight = multiplyShift | divisionShiftSelect | anyArithShift;

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    reg  [0:WORD_W-1] arithmetic_register_q;
    reg  [0:WORD_W-1] arithmetic_register_d;
    reg               carryOne_q;
    reg               carryOne_d;
    reg               carrySign_q;
    reg               carrySign_d;

    reg  [0:WORD_W-1] initInto;
    reg  [WORD_W+1:0] chain;
    reg               leftIn35;
    reg               rightIn0;
    integer           k;

    // ----------------------------------------
    // Next-value gating
    // ----------------------------------------
    // Strobes are single-cycle; several in one cycle apply in the
    // order below, matching the order the sequencer issues them, except that
    // shifts and the sign's own carry initiate read the registered word, not the gated value.
    always @* begin
        arithmetic_register_d = arithmetic_register_q;
        carryOne_d            = 1'b0;
        carrySign_d           = 1'b0;
        initInto              = {WORD_W{1'b0}};
        chain                 = {(WORD_W+2){1'b0}};
        leftIn35              = 1'b0;
        rightIn0              = arithmetic_register_q[`ARG_SIGN_BIT];

        if (clearPulse) begin
            arithmetic_register_d = {WORD_W{1'b0}};
        end
        if (ioLoadPulse) begin
            arithmetic_register_d = arithmetic_register_d | ioBus;
        end
        if (switchLoadPulse) begin
            arithmetic_register_d = arithmetic_register_d | switchSync_q;
        end

        for (k = `ARG_CNT_FIELD_LO; k <= `ARG_CNT_FIELD_HI; k = k + 1) begin
            if (clearLowBytePulse) begin
                arithmetic_register_d[k] = 1'b0;
            end
            if (setLowBytePulse) begin
                arithmetic_register_d[k] = 1'b1;
            end
            if (counterJamPulse) begin
                arithmetic_register_d[k] = shiftCounter[k];
            end
        end
        if (counterShortJamPulse) begin
            for (k = 0; k <= `ARG_REG_SHORT_HI; k = k + 1) begin
                arithmetic_register_d[k] = shiftCounter[k + `ARG_CNT_SHORT_LO];
            end
        end

        // Left end inputs: bit 35 source chosen before sign source
        if (singleRotate) begin
            leftIn35 = arithmetic_register_q[`ARG_SIGN_BIT];
        end else if (combinedArithShift) begin
            leftIn35 = multiplierQuotient[1];
        end else if (combinedLogicalShift | combinedRotate | divisionShiftSelect) begin
            leftIn35 = multiplierQuotient[0];
        end
        if (singleArithShift | singleLogicalShift | characterDeposit) begin
            leftIn35 = 1'b0;
        end

        // Right end input for the sign
        if (holdSignRight) begin
            rightIn0 = arithmetic_register_q[`ARG_SIGN_BIT];
        end else if (characterLoad | singleLogicalShift | combinedLogicalShift) begin
            rightIn0 = 1'b0;
        end else if (combinedRotate) begin
            rightIn0 = multiplierQuotient[WORD_W-1];
        end else if (singleRotate) begin
            rightIn0 = arithmetic_register_q[WORD_W-1];
        end

        if (shiftLeftPulse) begin
            for (k = 1; k < WORD_W - 1; k = k + 1) begin
                arithmetic_register_d[k] = arithmetic_register_q[k + 1];
            end
            if (!anyArithShift) begin
                arithmetic_register_d[`ARG_SIGN_BIT] =
                    arithmetic_register_q[`ARG_TOP_MAG_BIT];
            end
            arithmetic_register_d[WORD_W-1] = leftIn35;
        end else if (shiftRightPulse) begin
            for (k = 1; k < WORD_W; k = k + 1) begin
                arithmetic_register_d[k] = arithmetic_register_q[k - 1];
            end
            arithmetic_register_d[`ARG_SIGN_BIT] = rightIn0;
        end

        // Buffer gates: ones alone OR, zeros alone AND, both copy
        if (bufferOnesPulse && bufferZerosPulse) begin
            arithmetic_register_d = memoryBuffer;
        end else if (bufferOnesPulse) begin
            arithmetic_register_d = arithmetic_register_d | memoryBuffer;
        end else if (bufferZerosPulse) begin
            arithmetic_register_d = arithmetic_register_d & memoryBuffer;
        end

        if (bufferXorPulse) begin
            arithmetic_register_d = arithmetic_register_d ^ memoryBuffer;
        end
        if (complementPulse) begin
            arithmetic_register_d = ~arithmetic_register_d;
        end

        // Carry initiate senses partial sum 0 with buffer 1
        if (carryInitiatePulse) begin
            for (k = 1; k < WORD_W; k = k + 1) begin
                initInto[k - 1] = ~arithmetic_register_d[k] & memoryBuffer[k];
            end
            chain = rippleChain(arithmetic_register_d, initInto, 1'b0, 1'b0);
            arithmetic_register_d = chain[WORD_W-1:0];
            carryOne_d  = chain[WORD_W];
            // Sign position can initiate its own carry out
            carrySign_d = chain[WORD_W+1] |
                (~arithmetic_register_q[`ARG_SIGN_BIT] & memoryBuffer[`ARG_SIGN_BIT] &
                 ~bufferXorPulse) |
                (bufferXorPulse & ~(arithmetic_register_q[`ARG_SIGN_BIT] ^
                 memoryBuffer[`ARG_SIGN_BIT]) & memoryBuffer[`ARG_SIGN_BIT]);
        end

        if (increment_pulse || halfCarryPulse) begin
            chain = rippleChain(arithmetic_register_d, {WORD_W{1'b0}},
                                increment_pulse, halfCarryPulse);
            arithmetic_register_d = chain[WORD_W-1:0];
            carryOne_d  = carryOne_d | chain[WORD_W];
            carrySign_d = carrySign_d | chain[WORD_W+1];
        end
    end

    // ----------------------------------------
    // Register update
    // ----------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            arithmetic_register_q <= `ARG_REG_RESET;
            carryOne_q            <= 1'b0;
            carrySign_q           <= 1'b0;
        end else begin
            arithmetic_register_q <= arithmetic_register_d;
            carryOne_q            <= carryOne_d;
            carrySign_q           <= carrySign_d;
        end
    end

    assign arithmeticRegister = arithmetic_register_q;
    assign carryOutBitOne     = carryOne_q;
    assign carryOutSign       = carrySign_q;

endmodule // arith_register_input_gating

// ==== shared/arith_gating_defines.vh ====
`ifndef ARITH_GATING_DEFINES_VH
`define ARITH_GATING_DEFINES_VH

// ----------------------------------------
// Word layout, bit 0 is the sign
// ----------------------------------------
`define ARG_WORD_W      36
`define ARG_SIGN_BIT    0
`define ARG_TOP_MAG_BIT 1
`define ARG_LSB_BIT     35
`define ARG_HALF_LSB    17

// ----------------------------------------
// Shift counter field positions
// ----------------------------------------
`define ARG_CNT_W        9
`define ARG_CNT_FIELD_LO 1
`define ARG_CNT_FIELD_HI 8
`define ARG_CNT_SHORT_LO 3
`define ARG_REG_SHORT_HI 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ARG_REG_RESET   36'h0_0000_0000
`define ARG_SW_RESET    36'h0_0000_0000

`endif

// ==== verification/buffer_model.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// Memory buffer and quotient model
// ----------------------------------------
module buffer_model (
    input  logic        clock,
    input  logic        load,
    input  logic [0:35] bufIn,
    input  logic [0:35] quoIn,
    output logic [0:35] memoryBuffer = 36'h0_0000_0000,
    output logic [0:35] multiplierQuotient = 36'h0_0000_0000
);
    // Held steady across both add steps
    always @(posedge clock) begin
        if (load) begin
            memoryBuffer <= bufIn;
            multiplierQuotient <= quoIn;
        end
    end
endmodule  // buffer_model

// ==== verification/arith_gating_sva.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module arith_gating_sva (
    input logic        clock, rst_n,
    input logic        clearPulse, clearLowBytePulse, setLowBytePulse, counterJamPulse,
    input logic        counterShortJamPulse, ioLoadPulse, switchLoadPulse, shiftLeftPulse,
    input logic        shiftRightPulse, bufferOnesPulse, bufferZerosPulse, bufferXorPulse,
    input logic        complementPulse, carryInitiatePulse, increment_pulse, halfCarryPulse,
    input logic        divideInstr, normalizeReturnFlagTwo, divisionShiftSelect, carryOutSign,
    input logic [0:35] memoryBuffer, arithmeticRegister
);
    wire [15:0] st = {clearPulse, clearLowBytePulse, setLowBytePulse, counterJamPulse,
        counterShortJamPulse, ioLoadPulse, switchLoadPulse, shiftLeftPulse, shiftRightPulse,
        bufferOnesPulse, bufferZerosPulse, bufferXorPulse, complementPulse,
        carryInitiatePulse, increment_pulse, halfCarryPulse};
    // Lone strobes only, same-cycle mixes follow the chosen order
    wire        solo = $onehot(st);
    wire [0:35] rw = arithmeticRegister;
    wire [0:35] bw = memoryBuffer;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_clr; clearPulse && solo |=> rw == 36'h0_0000_0000; endproperty
    a_clr: assert property (p_clr) else $error("clear failed");
    property p_or; bufferOnesPulse && solo |=> rw == ($past(rw) | $past(bw)); endproperty
    a_or: assert property (p_or) else $error("or failed");
    property p_and; bufferZerosPulse && solo |=> rw == ($past(rw) & $past(bw)); endproperty
    a_and: assert property (p_and) else $error("and failed");
    property p_xor; bufferXorPulse && solo |=> rw == ($past(rw) ^ $past(bw)); endproperty
    a_xor: assert property (p_xor) else $error("xor failed");
    property p_cpl; complementPulse && solo |=> rw == ~$past(rw); endproperty
    a_cpl: assert property (p_cpl) else $error("complement failed");
    property p_inc; increment_pulse && solo |=> rw == $past(rw) + 36'h0_0000_0001; endproperty
    a_inc: assert property (p_inc) else $error("increment failed");
    property p_sum; carryInitiatePulse && solo |=> rw == ($past(rw) ^ $past(bw)) + $past(bw);
    endproperty
    a_sum: assert property (p_sum) else $error("carry initiate failed");
    property p_dss; divisionShiftSelect == (divideInstr && !normalizeReturnFlagTwo); endproperty
    a_dss: assert property (p_dss) else $error("divide select failed");
    property p_cos; increment_pulse && solo && (&rw) |=> carryOutSign; endproperty
    a_cos: assert property (p_cos) else $error("sign carry missing");
    property p_cosc; carryOutSign |-> $past(increment_pulse) || $past(carryInitiatePulse)
        || $past(halfCarryPulse); endproperty
    a_cosc: assert property (p_cosc) else $error("sign carry without cause");
endmodule  // arith_gating_sva

bind arith_register_input_gating arith_gating_sva i_sva (.*);

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin error_cnt++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_top;
    // ----------------------------------------
    // Strobe masks, stimulus, instances
    // ----------------------------------------
    localparam [15:0] CLR = 16'h0001, LOB = 16'h0002, SETB = 16'h0004, SCJ = 16'h0008;
    localparam [15:0] SCS = 16'h0010, IO = 16'h0020, SW = 16'h0040, SHL = 16'h0080;
    localparam [15:0] SHR = 16'h0100, ONES = 16'h0200, ZER = 16'h0400, XR = 16'h0800;
    localparam [15:0] CPL = 16'h1000, CI = 16'h2000, INC = 16'h4000, HLF = 16'h8000;
    localparam [35:0] A = 36'h8_0000_0001, Q = 36'hC_0000_0000;
    logic        clock = 0, rst_n = 0, load = 0;
    logic [15:0] stb = 0;
    logic [10:0] md = 0;
    logic [0:8]  cnt = 9'h0A5;
    logic [0:35] ioBus = 0, sws = 0, bufIn = 0, quoIn = 0;
    wire  [0:35] regOut, bufOut, quoOut;
    wire         dss, cob, cos;
    int          error_cnt = 0, tests_run = 0;
    buffer_model i_buf (.clock(clock), .load(load), .bufIn(bufIn), .quoIn(quoIn),
        .memoryBuffer(bufOut), .multiplierQuotient(quoOut));
    arith_register_input_gating i_dut (.clock(clock), .rst_n(rst_n), .clearPulse(stb[0]),
        .clearLowBytePulse(stb[1]), .setLowBytePulse(stb[2]), .counterJamPulse(stb[3]),
        .counterShortJamPulse(stb[4]), .shiftCounter(cnt), .ioLoadPulse(stb[5]), .ioBus(ioBus),
        .switchLoadPulse(stb[6]), .dataSwitches(sws), .shiftLeftPulse(stb[7]),
        .shiftRightPulse(stb[8]), .singleArithShift(md[0]), .combinedArithShift(md[1]),
        .singleLogicalShift(md[2]), .combinedLogicalShift(md[3]), .singleRotate(md[4]),
        .combinedRotate(md[5]), .characterLoad(md[6]), .characterDeposit(md[7]),
        .multiplyShift(md[8]), .divideInstr(md[9]), .normalizeReturnFlagTwo(md[10]),
        .multiplierQuotient(quoOut), .memoryBuffer(bufOut), .bufferOnesPulse(stb[9]),
        .bufferZerosPulse(stb[10]), .bufferXorPulse(stb[11]), .complementPulse(stb[12]),
        .carryInitiatePulse(stb[13]), .increment_pulse(stb[14]), .halfCarryPulse(stb[15]),
        .arithmeticRegister(regOut), .divisionShiftSelect(dss), .carryOutBitOne(cob),
        .carryOutSign(cos));
    initial forever #4 clock = ~clock;
    task automatic strobe(input [15:0] m);
        @(negedge clock) stb = m;
        @(negedge clock) stb = 0;
    endtask
    task automatic op(input [15:0] m, input [35:0] e, input string n);
        strobe(m);
        `CHK(n, e, regOut)
    endtask
    // Ones-only load, so the clear must come first
    task automatic put(input [35:0] v);
        ioBus = v;
        strobe(CLR);
        strobe(IO);
    endtask
    task automatic setBuf(input [35:0] b, input [35:0] q);
        @(negedge clock) bufIn = b;
        quoIn = q;
        load = 1;
        @(negedge clock) load = 0;
    endtask
    task automatic s_load;
        sws = 36'h1_2345_6789;
        put(36'hF_0000_0000);
        ioBus = 36'h0_0000_00F0;
        op(IO, 36'hF_0000_00F0, "ioOr");
        op(CLR, 36'h0_0000_0000, "clear");
        op(SW, 36'h1_2345_6789, "switch");
        op(SETB, 36'h7_FB45_6789, "setByte");
        op(LOB, 36'h0_0345_6789, "clrByte");
        op(SCJ, 36'h5_2B45_6789, "scJam");
        op(SCS, 36'h9_6B45_6789, "scShort");
    endtask
    task automatic s_logic;
        setBuf(36'h5_5555_5555, Q);
        put(36'h3_3333_3333);
        op(XR, 36'h6_6666_6666, "xor");
        op(CPL, 36'h9_9999_9999, "cpl");
        op(ONES, 36'hD_DDDD_DDDD, "or");
        op(ZER, 36'h5_5555_5555, "and");
        put(36'h3_3333_3333);
        op(ONES | ZER, 36'h5_5555_5555, "copy");
    endtask
    task automatic sh(input bit l, input [10:0] m, input [35:0] e);
        put(A);
        md = m;
        op(l ? SHL : SHR, e, "shift");
        `CHK("divSel", m[9] & ~m[10], dss)
        md = 0;
    endtask
    task automatic s_shift;
        sh(1, 11'h000, 36'h0_0000_0002);
        sh(1, 11'h010, 36'h0_0000_0003);
        sh(1, 11'h002, 36'h8_0000_0003);
        sh(1, 11'h008, 36'h0_0000_0003);
        sh(1, 11'h020, 36'h0_0000_0003);
        sh(1, 11'h200, 36'h0_0000_0003);
        sh(1, 11'h600, 36'h0_0000_0002);
        sh(1, 11'h001, 36'h8_0000_0002);
        sh(1, 11'h004, 36'h0_0000_0002);
        sh(1, 11'h080, 36'h0_0000_0002);
        sh(0, 11'h020, 36'h4_0000_0000);
        sh(0, 11'h010, 36'hC_0000_0000);
        sh(0, 11'h040, 36'h4_0000_0000);
        sh(0, 11'h004, 36'h4_0000_0000);
        sh(0, 11'h100, 36'hC_0000_0000);
        sh(0, 11'h200, 36'hC_0000_0000);
        sh(0, 11'h001, 36'hC_0000_0000);
    endtask
    task automatic s_inc;
        put(36'h0_0000_00FF);
        op(INC, 36'h0_0000_0100, "inc");
        put(36'h0_0003_FFFF);
        op(INC, 36'h0_0004_0000, "halfRipple");
        put(36'h0_0000_0005);
        op(INC | HLF, 36'h0_0004_0006, "bothHalves");
        put(36'hF_FFFF_FFFF);
        op(INC, 36'h0_0000_0000, "wrap");
        `CHK("incSign", 1'b1, cos)
    endtask
    task automatic add(input [35:0] a, b, s, input c1, c0);
        setBuf(b, Q);
        put(a);
        op(XR, a ^ b, "partial");
        op(CI, s, "sum");
        `CHK("carryBit1", c1, cob)
        `CHK("carrySign", c0, cos)
    endtask
    initial begin
        repeat (20) @(negedge clock);
        rst_n = 1;
        s_load();
        s_logic();
        s_shift();
        s_inc();
        add(36'h7_FFFF_FFFF, 36'h0_0000_0001, 36'h8_0000_0000, 1, 0);
        add(36'hF_FFFF_FFFF, 36'h0_0000_0001, 36'h0_0000_0000, 1, 1);
        add(36'h8_0000_0000, 36'h8_0000_0000, 36'h0_0000_0000, 0, 1);
        add(36'h1_2345_6789, 36'h0_ABCD_EF01, 36'h1_CF13_568A, 0, 0);
        print_verdict();
    end
    // Hang guard
    initial begin
        repeat (5000) @(posedge clock);
        error_cnt++;
        print_verdict();
    end
    task automatic print_verdict;
        if (error_cnt == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
endmodule  // tb_top
